// ===== rtl/rac_alias_reg.v
// One base register with its set, clear and toggle aliases.
// Assumes one clock, synchronous active-low reset, one-cycle write strobes.
`default_nettype none

module rac_alias_reg #(
   parameter             WIDTH = 8,
   parameter [WIDTH-1:0] RST   = {WIDTH{1'b0}},
   parameter [WIDTH-1:0] MASK  = {WIDTH{1'b1}}
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             sw_rst_i,
   input  wire             wr_base_i,
   input  wire             wr_set_i,
   input  wire             wr_clr_i,
   input  wire             wr_tgl_i,
   input  wire [WIDTH-1:0] wdata_i,
   output wire [WIDTH-1:0] value_o
);

   reg  [WIDTH-1:0] val_ff;
   reg  [WIDTH-1:0] nxt_val;
   wire [WIDTH-1:0] wd;

   // Reserved positions never store, so they read zero
   assign wd = wdata_i & MASK;

   always @* begin
      nxt_val = val_ff;
      if (wr_base_i) begin
         nxt_val = wd;
      end else if (wr_set_i) begin
         nxt_val = val_ff | wd;
      end else if (wr_clr_i) begin
         nxt_val = val_ff & ~wd;
      end else if (wr_tgl_i) begin
         nxt_val = val_ff ^ wd;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i || sw_rst_i) begin
         val_ff <= RST & MASK;
      end else begin
         val_ff <= nxt_val;
      end
   end

   assign value_o = val_ff;

endmodule

`default_nettype wire

// ===== rtl/rac_consts.vh
// Constants for the register bank access-convention block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef RAC_CONSTS_VH
`define RAC_CONSTS_VH

// Register indices on the local access port (word addressed)
`define RAC_IDX_CTRL      4'h0
`define RAC_IDX_STATUS    4'h1
`define RAC_IDX_CMD       4'h2
`define RAC_IDX_OUT       4'h3
`define RAC_IDX_OUT_SET   4'h4
`define RAC_IDX_OUT_CLR   4'h5
`define RAC_IDX_OUT_TGL   4'h6
`define RAC_IDX_DBG       4'h7

// Implemented-bit masks; all other bits are reserved
`define RAC_CTRL_MASK     8'h3F
`define RAC_STATUS_MASK   8'h0F
`define RAC_CMD_MASK      8'h03
`define RAC_OUT_MASK      8'hFF
`define RAC_DBG_MASK      8'h81

// Reset values
`define RAC_CTRL_RST      8'h00
`define RAC_OUT_RST       8'h00
`define RAC_DBG_RST       8'h00

// Command field positions
`define RAC_CMD_PULSE_BIT 0
`define RAC_CMD_SWRST_BIT 1

`endif

// ===== rtl/rac_reg_bank.v
// Peripheral register bank showing the documented bit access kinds.
// Assumes a processor-side port with one-cycle read/write strobes.
// Assumes status inputs are already synchronous to clk_i.
// Contract
// - Read/write bits return what was stored and take written values.
// - Read-only bits return live value; writes leave them unchanged.
// - Write-only bits accept writes; their read value is undefined.
// - Reserved bits always read zero regardless of writes.
// - Reset loads reset values; peripheral soft reset spares debug registers.
// - Base and its alias read back the same base value.
// - Clear alias clears base bits written one, single access.
// - Set alias sets base bits written one, visible through both.
// - Toggle alias inverts base bits written one, visible through both.
`default_nettype none
`include "rac_consts.vh"

module rac_reg_bank #(
   parameter WIDTH = 8
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire [3:0]       addr_i,
   input  wire             wr_i,
   input  wire             rd_i,
   input  wire [WIDTH-1:0] wdata_i,
   input  wire [3:0]       status_i,
   output reg  [WIDTH-1:0] rdata_o,
   output wire             rvalid_o,
   output reg  [WIDTH-1:0] ctrl_o,
   output wire [WIDTH-1:0] out_bits_o,
   output reg              pulse_o,
   output reg  [WIDTH-1:0] dbg_o
);

   // Access classes of one register index
   localparam [1:0] KIND_NONE = 2'b00;
   localparam [1:0] KIND_RW   = 2'b01;
   localparam [1:0] KIND_RO   = 2'b10;
   localparam [1:0] KIND_WO   = 2'b11;

   // Base register plus its set, clear and toggle aliases
   localparam       N_SLOT    = 4;

   // Implemented-bit masks at port width
   localparam [WIDTH-1:0] CTRL_MASK   = `RAC_CTRL_MASK;
   localparam [WIDTH-1:0] STATUS_MASK = `RAC_STATUS_MASK;
   localparam [WIDTH-1:0] CMD_MASK    = `RAC_CMD_MASK;
   localparam [WIDTH-1:0] DBG_MASK    = `RAC_DBG_MASK;

   reg               sw_rst_ff;
   reg               rvalid_ff;
   reg  [WIDTH-1:0]  nxt_rdata;
   wire [1:0]        kind;
   wire              rd_open;
   wire              wr_ok;
   wire              wr_cmd;
   wire              wr_ctrl;
   wire              wr_dbg;
   wire              swrst_req;
   wire              pulse_req;
   wire [3:0]        slot_off;
   wire [N_SLOT-1:0] wr_slot;
   wire [WIDTH-1:0]  cmd_bits;
   wire [WIDTH-1:0]  ctrl_wval;
   wire [WIDTH-1:0]  dbg_wval;
   wire [WIDTH-1:0]  status_word;

   // Exact index match
   function hit;
      input [3:0] a;
      input [3:0] idx;
      begin
         hit = (a == idx);
      end
   endfunction

   // One decode drives both the write gate and the read gate
   function [1:0] access_kind;
      input [3:0] a;
      begin
         case (a)
            `RAC_IDX_CTRL:    access_kind = KIND_RW;
            `RAC_IDX_STATUS:  access_kind = KIND_RO;
            `RAC_IDX_CMD:     access_kind = KIND_WO;
            `RAC_IDX_OUT:     access_kind = KIND_RW;
            `RAC_IDX_OUT_SET: access_kind = KIND_RW;
            `RAC_IDX_OUT_CLR: access_kind = KIND_RW;
            `RAC_IDX_OUT_TGL: access_kind = KIND_RW;
            `RAC_IDX_DBG:     access_kind = KIND_RW;
            default:          access_kind = KIND_NONE;
         endcase
      end
   endfunction

   // Classify the index once per cycle
   assign kind      = access_kind(addr_i);
   // Read-only and unmapped slots get no write enable at all
   assign wr_ok     = wr_i && (kind == KIND_RW || kind == KIND_WO);
   // Write-only and unmapped slots read zero
   assign rd_open   = (kind == KIND_RW) || (kind == KIND_RO);
   assign wr_cmd    = wr_ok && hit(addr_i, `RAC_IDX_CMD);
   assign wr_ctrl   = wr_ok && hit(addr_i, `RAC_IDX_CTRL);
   assign wr_dbg    = wr_ok && hit(addr_i, `RAC_IDX_DBG);

   // Reserved positions are dropped before they can be stored
   assign cmd_bits  = wdata_i & CMD_MASK;
   assign ctrl_wval = wdata_i & CTRL_MASK;
   assign dbg_wval  = wdata_i & DBG_MASK;
   assign swrst_req = wr_cmd && cmd_bits[`RAC_CMD_SWRST_BIT];
   assign pulse_req = wr_cmd && cmd_bits[`RAC_CMD_PULSE_BIT];

   // Slot 0 is the base; indices below it wrap past N_SLOT
   assign slot_off  = addr_i - `RAC_IDX_OUT;

   // Write enables for the base and its aliases
   genvar g;

   generate
      for (g = 0; g < N_SLOT; g = g + 1) begin : g_slot
         assign wr_slot[g] = wr_ok && (slot_off == g);
      end
   endgenerate

   // Soft reset is registered so the writing access completes first
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         sw_rst_ff <= 1'b0;
      end else begin
         sw_rst_ff <= swrst_req;
      end
   end

   // Command pulse lasts exactly one clock
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= pulse_req;
      end
   end

   // Control: plain read/write bits
   always @(posedge clk_i) begin
      if (!rst_n_i || sw_rst_ff) begin
         ctrl_o <= `RAC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_o <= ctrl_wval;
      end
   end

   // Debug control: power-on reset only, kept over soft reset
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         dbg_o <= `RAC_DBG_RST;
      end else if (wr_dbg) begin
         dbg_o <= dbg_wval;
      end
   end

   // Base and alias writes share one register, so a pair cannot drift
   // Only one index is decoded per cycle, so alias priority never matters
   rac_alias_reg #(
      .WIDTH (WIDTH),
      .RST   (`RAC_OUT_RST),
      .MASK  (`RAC_OUT_MASK)
   ) u_out (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .sw_rst_i  (sw_rst_ff),
      .wr_base_i (wr_slot[0]),
      .wr_set_i  (wr_slot[1]),
      .wr_clr_i  (wr_slot[2]),
      .wr_tgl_i  (wr_slot[3]),
      .wdata_i   (wdata_i),
      .value_o   (out_bits_o)
   );

   // Status is sampled live, never stored
   assign status_word = {{(WIDTH-4){1'b0}}, status_i} & STATUS_MASK;

   // Same-cycle write and read returns the value before the write
   always @* begin
      nxt_rdata = {WIDTH{1'b0}};
      if (rd_open) begin
         case (addr_i)
            `RAC_IDX_CTRL:    nxt_rdata = ctrl_o;
            `RAC_IDX_STATUS:  nxt_rdata = status_word;
            `RAC_IDX_OUT,
            `RAC_IDX_OUT_SET,
            `RAC_IDX_OUT_CLR,
            `RAC_IDX_OUT_TGL: nxt_rdata = out_bits_o;
            `RAC_IDX_DBG:     nxt_rdata = dbg_o;
            default:          nxt_rdata = {WIDTH{1'b0}};
         endcase
      end
   end

   // Read data holds between reads, so a late sampler still sees it
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= {WIDTH{1'b0}};
      end else if (rd_i) begin
         rdata_o <= nxt_rdata;
      end
   end

   // Valid marks the one cycle after each read strobe
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= rd_i;
      end
   end

   assign rvalid_o = rvalid_ff;

endmodule

`default_nettype wire

// ===== sim/rac_cpu_model.sv
// Processor-side model issuing one-cycle register strobes.
// Assumes each task is entered just after a rising edge.
`default_nettype none
module rac_cpu_model (
   input wire logic       clk_i, rvalid_i,
   input wire logic [7:0] rdata_i,
   output logic           wr_o, rd_o,
   output logic [3:0]     addr_o,
   output logic [7:0]     wdata_o);
   timeunit 1ns; timeprecision 100ps;
   initial begin
      {wr_o, rd_o, addr_o, wdata_o} = 14'h0000;
   end
   // Released lines show the inverse so stale values never pass
   // One idle edge after each access keeps a strobe from toggling twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
      @(posedge clk_i) #1;
      {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
      @(posedge clk_i) #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      {addr_o, rd_o} = {a, 1'b1};
      @(posedge clk_i) #1;
      {addr_o, rd_o} = {~a, 1'b0};
      d = rvalid_i ? rdata_i : ~rdata_i;
      @(posedge clk_i) #1;
   endtask
endmodule
`default_nettype wire

// ===== sim/rac_monitor.sv
// Port checker for the register bank.
// Assumes binding onto rac_reg_bank; one clock, sync reset.
`default_nettype none
module rac_monitor #(parameter WIDTH = 8) (
   input wire logic             clk_i, rst_n_i, wr_i, rd_i, rvalid_o,
   input wire logic [3:0]       addr_i, status_i,
   input wire logic [WIDTH-1:0] wdata_i, rdata_o, ctrl_o, out_bits_o, dbg_o);
   logic      srq_ff;
   wire [3:0] wa = wr_i ? addr_i : 4'hF;
   wire [7:0] ob = out_bits_o;
   // Soft reset lands one edge after the command write
   always_ff @(posedge clk_i) srq_ff <= rst_n_i && wa == 4'h2 && wdata_i[1];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_set; wa == 4'h4 && !srq_ff |=> ob == $past(ob | wdata_i); endproperty
   a_set: assert property (p_set) else $error("set alias wrong");
   property p_clr; wa == 4'h5 && !srq_ff |=> ob == $past(ob & ~wdata_i); endproperty
   a_clr: assert property (p_clr) else $error("clear alias wrong");
   property p_tgl; wa == 4'h6 && !srq_ff |=> ob == $past(ob ^ wdata_i); endproperty
   a_tgl: assert property (p_tgl) else $error("toggle alias wrong");
   property p_hold; !(wa inside {[4'h3:4'h6]}) && !srq_ff |=> $stable(ob); endproperty
   a_hold: assert property (p_hold) else $error("base changed unasked");
   property p_srst; srq_ff |=> ob == 8'h00 && ctrl_o == 8'h00; endproperty
   a_srst: assert property (p_srst) else $error("soft reset missed");
   property p_dbg; srq_ff && wa != 4'h7 |=> $stable(dbg_o); endproperty
   a_dbg: assert property (p_dbg) else $error("debug lost on soft reset");
   property p_rsv; ctrl_o[7:6] == 2'h0 && (dbg_o & 8'h7E) == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_pair; rd_i && addr_i inside {[4'h3:4'h6]} |=> rvalid_o && rdata_o == $past(ob);
   endproperty
   a_pair: assert property (p_pair) else $error("pair read differs");
   c_srst: cover property (srq_ff);
   c_tgl: cover property (wa == 4'h6);
   c_ro: cover property (rd_i && addr_i == 4'h1);
endmodule
bind rac_reg_bank rac_monitor #(.WIDTH(WIDTH)) u_rac_monitor (.*);
`default_nettype wire

// ===== sim/rac_reg_bank_bench.sv
// Self-checking bench for the register bank and its aliases.
// Assumes the processor model drives every bus strobe.
`default_nettype none
module rac_reg_bank_bench;
   timeunit 1ns; timeprecision 100ps;
   logic       clk_i = 0, rst_n_i = 0;
   logic [3:0] status_i = 4'h0;
   wire        wr_i, rd_i, rvalid_o, pulse_o;
   wire  [3:0] addr_i;
   wire  [7:0] wdata_i, rdata_o, ctrl_o, out_bits_o, dbg_o;
   int         err_count = 0, compares = 0, cyc = 0, pulses = 0;
   always #12.5 clk_i = ~clk_i;
   // Pulse stands one cycle, so it is counted at every edge
   always @(posedge clk_i) if (pulse_o === 1'b1) pulses++;
   rac_reg_bank u_rac_reg_bank (.*);
   rac_cpu_model u_rac_cpu_model (.clk_i(clk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o),
      .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
   task automatic w(input logic [3:0] a, input logic [7:0] d);
      u_rac_cpu_model.wr(a, d);
   endtask
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_rac_cpu_model.rd(a, d);
      ck(d, e);
   endtask
   task automatic summarize;
      if (err_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic t_rw;
      w(4'h0, 8'hFF); rc(4'h0, 8'h3F);
      w(4'h7, 8'hFF); rc(4'h7, 8'h81);
      status_i = 4'hA; w(4'h1, 8'hFF); rc(4'h1, 8'h0A);
      w(4'h9, 8'hFF); rc(4'h9, 8'h00); rc(4'h0, 8'h3F);
   endtask
   task automatic t_alias;
      w(4'h3, 8'h5A); w(4'h4, 8'h81); rc(4'h4, 8'hDB);
      w(4'h5, 8'h18); rc(4'h5, 8'hC3);
      w(4'h6, 8'hF0); rc(4'h6, 8'h33); rc(4'h3, 8'h33);
   endtask
   task automatic t_srst;
      w(4'h2, 8'h02); rc(4'h0, 8'h00); rc(4'h3, 8'h00); rc(4'h7, 8'h81);
   endtask
   task automatic t_cmd;
      int p;
      p = pulses;
      w(4'h2, 8'h01);
      ck(8'(pulses - p), 8'h01);
      w(4'h2, 8'h00);
      ck(8'(pulses - p), 8'h01);
   endtask
   task automatic t_por;
      w(4'h0, 8'h15);
      rc(4'h0, 8'h15);
      rst_n_i = 0;
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1;
      rc(4'h7, 8'h00);
      rc(4'h0, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1;
      t_rw;
      t_alias;
      t_srst;
      t_cmd;
      t_por;
      summarize;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 400) begin
         err_count++;
         summarize;
      end
   end
endmodule
`default_nettype wire
